//--- sss_cfg.svh
// constants for the shunt current sampling scheduler
// Behaviour
// - convert a phase only in its low-side on window; avoid null/short low duty
// - three shunts: two simultaneous conversions, third current is minus their sum
// - skip phase A in sectors 1,6; B in 2,3; C in 4,5
// - reference low duty at or above dead time plus noise: sample at counter overflow
// - low duty between half threshold and dead time plus noise: sample after overflow
// - in that case start at least the noise time past the reference commutation
// - short low duty, big duty gap: start one sample time before high-side off
// - short low duty and small duty gap: flag that no sample is possible
// - single shunt: lower gates are the complements of the upper gates
// - shunt current decoded from upper switch states per the fixed table
// - centre-aligned period splits into seven subperiods; first, fourth, seventh carry zero
// - single shunt rebuilds each phase from signed subperiod samples; third is minus others
// - after-overflow point uses inverted trigger polarity, match while counting down
// - each control update reloads channel selection for next period, and compare value unless no sample is possible
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
`define SSS_PH_A 2'h0
`define SSS_PH_B 2'h1
`define SSS_PH_C 2'h2
`define SSS_SUB_FIRST 3'h1
`define SSS_SUB_II 3'h2
`define SSS_SUB_III 3'h3
`define SSS_SUB_LAST 3'h7
`define SSS_SUB_STEP 3'h1
`define SSS_POL_NORMAL 1'b0
`define SSS_POL_INVERT 1'b1
`endif

//--- sss_pkg.sv
// types of the shunt current sampling scheduler
package sss_pkg;
    // one-hot timing case chosen at each update
    typedef enum logic [3:0] {
        SSS_CASE_OVF = 4'b0001,
        SSS_CASE_AFTER = 4'b0010,
        SSS_CASE_BEFORE = 4'b0100,
        SSS_CASE_NONE = 4'b1000
    } sss_case_t;
endpackage : sss_pkg

//--- sss_dec_if.sv
// carrier between the scheduler and its shunt decoder
`timescale 1ns/10ps
`default_nettype none
interface sss_dec_if;
    logic [2:0] hs;
    logic zero;
    logic neg;
    logic [1:0] phase;
    modport dec (input hs, output zero, neg, phase);
    modport user (output hs, input zero, neg, phase);
endinterface : sss_dec_if
`default_nettype wire

//--- sss_decode.sv
// single shunt current decoder from upper switch states
`timescale 1ns/10ps
`default_nettype none
`include "sss_cfg.svh"
module sss_decode (
    // decoder carrier
    sss_dec_if.dec dif
);
    // hs[2]=phase A upper, hs[1]=B, hs[0]=C; 1 means closed
    always_comb begin
        dif.zero = 1'b0;
        dif.neg = 1'b0;
        dif.phase = `SSS_PH_A;
        unique case (dif.hs)
            3'b000, 3'b111: dif.zero = 1'b1;
            3'b011: dif.phase = `SSS_PH_A;
            3'b001: begin
                dif.phase = `SSS_PH_C;
                dif.neg = 1'b1;
            end
            3'b101: dif.phase = `SSS_PH_B;
            3'b100: dif.neg = 1'b1;
            3'b110: dif.phase = `SSS_PH_C;
            3'b010: begin
                dif.phase = `SSS_PH_B;
                dif.neg = 1'b1;
            end
        endcase
    end
endmodule : sss_decode
`default_nettype wire

//--- sss_top.sv
// shunt current sampling scheduler top
`timescale 1ns/10ps
`default_nettype none
`include "sss_cfg.svh"
module sss_top
    import sss_pkg::*;
#(
    parameter int CW = 16,
    parameter int DW = 12
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // pwm timer
    input wire logic [CW-1:0] cnt_in,
    input wire logic cnt_down_in,
    input wire logic [CW-1:0] period_in,
    input wire logic [2:0] hs_gate_in,
    // control computation
    input wire logic update_in,
    input wire logic [2:0] sector_in,
    input wire logic [CW-1:0] duty_a_in,
    input wire logic [CW-1:0] duty_b_in,
    input wire logic [CW-1:0] duty_c_in,
    input wire logic single_shunt_in,
    // timing configuration in ticks
    input wire logic [CW-1:0] dead_time_in,
    input wire logic [CW-1:0] noise_in,
    input wire logic [CW-1:0] rise_in,
    input wire logic [CW-1:0] sample_in,
    // converter results
    input wire logic adc_valid_in,
    input wire logic signed [DW-1:0] adc0_in,
    input wire logic signed [DW-1:0] adc1_in,
    // trigger and selection
    output logic [CW-1:0] trigger_compare_value_out,
    output logic trigger_output_polarity_out,
    output logic [1:0] chan0_out,
    output logic [1:0] chan1_out,
    output logic no_sample_out,
    output logic trig_out,
    output logic [2:0] ls_gate_out,
    output logic [2:0] subperiod_out,
    // rebuilt phase currents
    output logic signed [DW+1:0] cur_a_out,
    output logic signed [DW+1:0] cur_b_out,
    output logic signed [DW+1:0] cur_c_out,
    output logic cur_valid_out
);
    localparam int SW = CW + 2;
    localparam int QW = DW + 2;

    generate
        if (CW < 4 || DW < 4) begin : g_bad_width
            $error("sss_top: CW and DW must be at least 4");
        end
    endgenerate

    typedef struct packed {
        logic [CW-1:0] cmp;
        logic pol;
        logic [1:0] ch0;
        logic [1:0] ch1;
        logic none;
        sss_case_t kase;
        logic trig;
        logic [2:0] ls;
        logic [2:0] hs_prev;
        logic [2:0] sub;
        logic [1:0] pend_ph;
        logic pend_neg;
        logic [2:0] got;
        logic [2:0][QW-1:0] cur;
        logic valid;
    } sss_state_t;

    sss_state_t st_r;
    sss_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [1:0] skip_of(input logic [2:0] sec);
        unique case (sec)
            3'h1, 3'h6: skip_of = `SSS_PH_A;
            3'h2, 3'h3: skip_of = `SSS_PH_B;
            default: skip_of = `SSS_PH_C; // sectors 4,5; illegal codes too
        endcase
    endfunction : skip_of

    function automatic logic [CW-1:0] duty_of(input logic [1:0] ph);
        unique case (ph)
            `SSS_PH_A: duty_of = duty_a_in;
            `SSS_PH_B: duty_of = duty_b_in;
            default: duty_of = duty_c_in;
        endcase
    endfunction : duty_of

    // third current is minus the sum of the other two
    function automatic logic [QW-1:0] neg_sum(input logic [QW-1:0] x,
                                              input logic [QW-1:0] y);
        neg_sum = QW'(-($signed(x) + $signed(y)));
    endfunction : neg_sum

    ////////////////////////////////////////////////////////////////////////
    // phase choice and case thresholds
    logic [1:0] skip_ph;
    logic [1:0] p0;
    logic [1:0] p1;
    logic [1:0] ref_ph;
    logic [1:0] nxt_ph;
    logic [SW-1:0] d_ref;
    logic [SW-1:0] d_gap;
    logic [SW-1:0] thr_dtn;
    logic [SW-1:0] thr_half;
    logic [SW-1:0] thr_gap;

    // the skipped phase is the one with least low-side on time
    always_comb begin
        skip_ph = skip_of(sector_in);
        unique case (skip_ph)
            `SSS_PH_A: begin
                p0 = `SSS_PH_B;
                p1 = `SSS_PH_C;
            end
            `SSS_PH_B: begin
                p0 = `SSS_PH_A;
                p1 = `SSS_PH_C;
            end
            default: begin
                p0 = `SSS_PH_A;
                p1 = `SSS_PH_B;
            end
        endcase
        // reference has the shorter low-side window of the sampled pair
        if (duty_of(p0) >= duty_of(p1)) begin
            ref_ph = p0;
            nxt_ph = p1;
        end else begin
            ref_ph = p1;
            nxt_ph = p0;
        end
        d_ref = SW'(period_in) - SW'(duty_of(ref_ph));
        d_gap = SW'(duty_of(ref_ph)) - SW'(duty_of(nxt_ph));
        thr_dtn = SW'(dead_time_in) + SW'(noise_in);
        thr_half = (thr_dtn + SW'(sample_in)) >> 1;
        thr_gap = SW'(dead_time_in) + SW'(rise_in) + SW'(sample_in);
    end

    ////////////////////////////////////////////////////////////////////////
    // shunt decoder
    sss_dec_if dif ();
    assign dif.hs = hs_gate_in;
    sss_decode u_dec (
        .dif(dif.dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic [2:0] got_new;
    logic [1:0] miss_ph;

    always_comb begin
        st_nxt = st_r;
        st_nxt.trig = 1'b0;
        st_nxt.valid = 1'b0;
        st_nxt.ls = ~hs_gate_in;
        got_new = st_r.got;
        miss_ph = `SSS_PH_A;
        // new sampling point for the following period
        if (update_in) begin
            st_nxt.ch0 = p0;
            st_nxt.ch1 = p1;
            st_nxt.none = 1'b0;
            // equality sits here too: a down-count match at the very top would never fire
            if (d_ref >= thr_dtn) begin
                st_nxt.kase = SSS_CASE_OVF;
                st_nxt.cmp = period_in;
                st_nxt.pol = `SSS_POL_NORMAL;
            end else if (d_ref > thr_half) begin
                st_nxt.kase = SSS_CASE_AFTER;
                // waits the noise time past the low-side switch-on
                st_nxt.cmp = CW'(SW'(period_in) + d_ref - thr_dtn);
                st_nxt.pol = `SSS_POL_INVERT;
            end else if (d_gap > thr_gap) begin
                st_nxt.kase = SSS_CASE_BEFORE;
                st_nxt.cmp = duty_of(ref_ph) - sample_in;
                st_nxt.pol = `SSS_POL_NORMAL;
            end else begin
                st_nxt.kase = SSS_CASE_NONE;
                st_nxt.none = 1'b1;
            end
        end
        // subperiod tracking, restarted at counter bottom
        st_nxt.hs_prev = hs_gate_in;
        if (cnt_in == '0) begin
            st_nxt.sub = `SSS_SUB_FIRST;
            st_nxt.got = '0;
            got_new = '0;
        end else if (hs_gate_in != st_r.hs_prev && st_r.sub != `SSS_SUB_LAST) begin
            st_nxt.sub = st_r.sub + `SSS_SUB_STEP;
        end
        if (single_shunt_in) begin
            // sample in the first half only; zero subperiods never trigger
            if (st_nxt.sub != st_r.sub && !dif.zero &&
                (st_nxt.sub == `SSS_SUB_II || st_nxt.sub == `SSS_SUB_III)) begin
                st_nxt.trig = 1'b1;
                st_nxt.pend_ph = dif.phase;
                st_nxt.pend_neg = dif.neg;
            end
            if (adc_valid_in) begin
                st_nxt.cur[st_r.pend_ph] = st_r.pend_neg ? QW'(-$signed(adc0_in)) :
                                                           QW'($signed(adc0_in));
                got_new[st_r.pend_ph] = 1'b1;
                st_nxt.got = got_new;
                // two distinct phases known: rebuild the third
                if (got_new != 3'h7 && (got_new[0] + got_new[1] + got_new[2]) == 2'h2) begin
                    miss_ph = !got_new[0] ? `SSS_PH_A : (!got_new[1] ? `SSS_PH_B : `SSS_PH_C);
                    unique case (miss_ph)
                        `SSS_PH_A: st_nxt.cur[0] = neg_sum(st_nxt.cur[1], st_nxt.cur[2]);
                        `SSS_PH_B: st_nxt.cur[1] = neg_sum(st_nxt.cur[0], st_nxt.cur[2]);
                        default: st_nxt.cur[2] = neg_sum(st_nxt.cur[0], st_nxt.cur[1]);
                    endcase
                    st_nxt.valid = 1'b1;
                end
            end
        end else begin
            // both conversions start on one compare match
            if (!st_r.none && cnt_in == st_r.cmp && cnt_down_in == st_r.pol) begin
                st_nxt.trig = 1'b1;
            end
            if (adc_valid_in) begin
                st_nxt.cur[st_r.ch0] = QW'($signed(adc0_in));
                st_nxt.cur[st_r.ch1] = QW'($signed(adc1_in));
                st_nxt.cur[skip_of(sector_of_ch(st_r.ch0, st_r.ch1))] =
                    neg_sum(QW'($signed(adc0_in)), QW'($signed(adc1_in)));
                st_nxt.valid = 1'b1;
            end
        end
    end

    // sector code whose skipped phase is the one not in the pair
    function automatic logic [2:0] sector_of_ch(input logic [1:0] a, input logic [1:0] b);
        if (a != `SSS_PH_A && b != `SSS_PH_A) sector_of_ch = 3'h1;
        else if (a != `SSS_PH_B && b != `SSS_PH_B) sector_of_ch = 3'h2;
        else sector_of_ch = 3'h4;
    endfunction : sector_of_ch

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            st_r <= '0;
            st_r.kase <= SSS_CASE_NONE;
            st_r.none <= 1'b1;
            st_r.ls <= '1;
            st_r.sub <= `SSS_SUB_FIRST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign trigger_compare_value_out = st_r.cmp;
    assign trigger_output_polarity_out = st_r.pol;
    assign chan0_out = st_r.ch0;
    assign chan1_out = st_r.ch1;
    assign no_sample_out = st_r.none;
    assign trig_out = st_r.trig;
    assign ls_gate_out = st_r.ls;
    assign subperiod_out = st_r.sub;
    assign cur_a_out = $signed(st_r.cur[0]);
    assign cur_b_out = $signed(st_r.cur[1]);
    assign cur_c_out = $signed(st_r.cur[2]);
    assign cur_valid_out = st_r.valid;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_upd;
        update_in;
    endsequence
    sequence s_upd_ovf;
        s_upd ##0 (d_ref >= thr_dtn);
    endsequence
    sequence s_upd_after;
        s_upd ##0 (d_ref < thr_dtn && d_ref > thr_half);
    endsequence

    property p_skip;
        s_upd ##0 (sector_in == 3'h1 || sector_in == 3'h6) |=>
            chan0_out != `SSS_PH_A && chan1_out != `SSS_PH_A;
    endproperty
    a_skip: assert property (p_skip) else $error("sampled phase A in sector 1 or 6");

    property p_two;
        s_upd |=> chan0_out != chan1_out;
    endproperty
    a_two: assert property (p_two) else $error("both conversions on one phase");
    property p_sum;
        adc_valid_in && !single_shunt_in |=> cur_valid_out &&
            QW'(cur_a_out + cur_b_out + cur_c_out) == '0;
    endproperty
    a_sum: assert property (p_sum) else $error("third current not minus the sum");

    property p_ovf;
        s_upd_ovf |=> trigger_compare_value_out == $past(period_in) &&
            trigger_output_polarity_out == `SSS_POL_NORMAL && !no_sample_out;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow case not at period");

    property p_after;
        s_upd_after |=> trigger_output_polarity_out == `SSS_POL_INVERT &&
            trigger_compare_value_out < $past(period_in);
    endproperty
    a_after: assert property (p_after) else $error("after-overflow case misplaced");

    property p_noise;
        s_upd_after |=>
            SW'(trigger_compare_value_out) + $past(thr_dtn) == SW'($past(period_in)) + $past(d_ref);
    endproperty
    a_noise: assert property (p_noise) else $error("noise wait not kept");

    property p_before;
        s_upd ##0 (d_ref <= thr_half && d_gap > thr_gap) |=>
            trigger_compare_value_out == $past(duty_of(ref_ph)) - $past(sample_in);
    endproperty
    a_before: assert property (p_before) else $error("before-switch-off case misplaced");

    property p_none;
        s_upd ##0 (d_ref <= thr_half && d_gap <= thr_gap && !single_shunt_in) |=> no_sample_out ##1 !trig_out;
    endproperty
    a_none: assert property (p_none) else $error("unsamplable case not flagged");

    property p_ls;
        1'b1 |=> ls_gate_out == ~$past(hs_gate_in);
    endproperty
    a_ls: assert property (p_ls) else $error("lower gates not complementary");

    property p_trig;
        trig_out && !$past(single_shunt_in) |-> $past(cnt_in) == $past(trigger_compare_value_out) &&
            $past(cnt_down_in) == $past(trigger_output_polarity_out);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger off the compare match");

    property p_sub;
        trig_out && $past(single_shunt_in) |->
            subperiod_out == `SSS_SUB_II || subperiod_out == `SSS_SUB_III;
    endproperty
    a_sub: assert property (p_sub) else $error("single shunt sample outside subperiod 2 or 3");
endmodule : sss_top
`default_nettype wire

//--- sss_pwm_adc.sv
// far side model: centre-aligned pwm timer and converter
`timescale 1ns/10ps
`default_nettype none
module sss_pwm_adc #(
    parameter int CW = 16,
    parameter int DW = 12
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // settings from the bench, start pulse from the scheduler
    input wire logic [CW-1:0] period_in,
    input wire logic [CW-1:0] duty_a_in,
    input wire logic [CW-1:0] duty_b_in,
    input wire logic [CW-1:0] duty_c_in,
    input wire logic trig_in,
    // timer and converter outputs
    output logic [CW-1:0] cnt_out,
    output logic cnt_down_out,
    output logic [2:0] hs_out,
    output logic adc_valid_out,
    output logic signed [DW-1:0] adc0_out,
    output logic signed [DW-1:0] adc1_out
);
    integer seed = 3;
    logic [2:0] wait_r = 3'h0;
    initial begin
        cnt_out = '0;
        cnt_down_out = 1'b0;
        adc_valid_out = 1'b0;
        adc0_out = '0;
        adc1_out = '0;
    end
    ////////////////////////////////////////////////////////////////
    // timer steps and converter answers, all on the falling edge
    always @(negedge clk_in) begin
        adc_valid_out <= 1'b0;
        adc0_out <= ~adc0_out; // idle lines toggle, so a stale result never holds steady
        adc1_out <= ~adc1_out;
        if (!resetn_in) begin
            cnt_out <= '0;
            cnt_down_out <= 1'b0;
            wait_r <= 3'h0;
        end else begin
            if (!cnt_down_out && cnt_out == period_in) begin
                cnt_down_out <= 1'b1;
                cnt_out <= cnt_out - 1'b1;
            end else if (cnt_down_out && cnt_out == 1) begin
                cnt_down_out <= 1'b0;
                cnt_out <= '0;
            end else begin
                cnt_out <= cnt_down_out ? cnt_out - 1'b1 : cnt_out + 1'b1;
            end
            // conversion takes three cycles after the start pulse
            if (trig_in) wait_r <= 3'h3;
            else if (wait_r != 3'h0) wait_r <= wait_r - 3'h1;
            if (wait_r == 3'h1) begin
                adc_valid_out <= 1'b1;
                adc0_out <= DW'($random(seed) % 500);
                adc1_out <= DW'($random(seed) % 500);
            end
        end
    end
    // upper gate closed while the counter is below its compare value
    assign hs_out = {cnt_out < duty_a_in, cnt_out < duty_b_in, cnt_out < duty_c_in};
endmodule : sss_pwm_adc
`default_nettype wire

//--- test_shunt_current_sampling_scheduler.sv
// self-checking bench for the shunt current sampling scheduler
`timescale 1ns/10ps
`default_nettype none
module test_shunt_current_sampling_scheduler;
    import sss_pkg::*;
    localparam int CW = 16;
    localparam int DW = 12;
    localparam int PER = 100;
    localparam int DT = 4;
    localparam int TN = 6;
    localparam int TR = 3;
    localparam int TS = 5;
    localparam logic [31:0] DEC = 32'h82140568;
    localparam int RD[4] = '{80, 92, 97, 97};
    localparam int ND[4] = '{50, 50, 77, 90};
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic update_in = 1'b0;
    logic single_shunt_in = 1'b0;
    logic [2:0] sector_in = 3'h1;
    logic [CW-1:0] duty_a_in = 16'h0, duty_b_in = 16'h0, duty_c_in = 16'h0;
    logic [CW-1:0] cnt_in, trigger_compare_value_out, e_cmp;
    logic cnt_down_in, adc_valid_in, trigger_output_polarity_out, no_sample_out, trig_out, cur_valid_out;
    logic [2:0] hs_gate_in, ls_gate_out, subperiod_out, hs_q, sub_e, pc;
    logic [1:0] chan0_out, chan1_out;
    logic signed [DW-1:0] adc0_in, adc1_in;
    logic signed [DW+1:0] cur_a_out, cur_b_out, cur_c_out;
    logic signed [DW+1:0] e_cur [3];
    logic e_pol, e_ns, pend, tp, vp, sub_ok, live, m3, have, spv;
    integer fails = 0, n_compared = 0, seed = 3, cyc = 0, ncv = 0;
    integer dr, dg, rf, p, q, sk, k, i, a, b, c, sph, sv;
    ////////////////////////////////////////////////////////////////
    // 125 MHz clock, design and far side
    always #4 core_clk_in = ~core_clk_in;
    sss_top #(.CW(CW), .DW(DW)) u_dut (.core_clk_in, .resetn_in, .cnt_in, .cnt_down_in,
        .period_in(CW'(PER)), .hs_gate_in, .update_in, .sector_in, .duty_a_in, .duty_b_in, .duty_c_in,
        .single_shunt_in, .dead_time_in(CW'(DT)), .noise_in(CW'(TN)), .rise_in(CW'(TR)),
        .sample_in(CW'(TS)), .adc_valid_in, .adc0_in, .adc1_in, .trigger_compare_value_out,
        .trigger_output_polarity_out, .chan0_out, .chan1_out, .no_sample_out, .trig_out, .ls_gate_out,
        .subperiod_out, .cur_a_out, .cur_b_out, .cur_c_out, .cur_valid_out);
    sss_pwm_adc #(.CW(CW), .DW(DW)) u_far (.clk_in(core_clk_in), .resetn_in, .period_in(CW'(PER)),
        .duty_a_in, .duty_b_in, .duty_c_in, .trig_in(trig_out), .cnt_out(cnt_in), .cnt_down_out(cnt_down_in),
        .hs_out(hs_gate_in), .adc_valid_out(adc_valid_in), .adc0_out(adc0_in), .adc1_out(adc1_in));
    ////////////////////////////////////////////////////////////////
    // compare, verdict and helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    function automatic integer skip_of(input integer s);
        return (s == 1 || s == 6) ? 0 : (s == 2 || s == 3) ? 1 : 2;
    endfunction : skip_of
    function automatic integer dty(input integer ph);
        return ph == 0 ? int'(duty_a_in) : ph == 1 ? int'(duty_b_in) : int'(duty_c_in);
    endfunction : dty
    task automatic put(input integer ph, input integer v);
        case (ph)
            0: duty_a_in = CW'(v);
            1: duty_b_in = CW'(v);
            default: duty_c_in = CW'(v);
        endcase
    endtask : put
    task automatic pulse(input integer s, input integer n);
        sector_in = s[2:0];
        update_in = 1'b1;
        @(negedge core_clk_in);
        update_in = 1'b0;
        repeat (n) @(negedge core_clk_in);
    endtask : pulse
    // hang guard, tests need about 20000 cycles
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    // reference model, read before the edge's updates land
    always @(posedge core_clk_in) begin
        if (!resetn_in) begin
            {live, pend, tp, vp, sub_ok, m3, have, spv} = 8'h0;
            sub_e = 3'h1;
        end else begin
            if (live) begin
                chk(ls_gate_out, 3'(~hs_q));
                if (sub_ok) chk(subperiod_out, sub_e);
                if (spv) chk(sph == 0 ? cur_a_out : sph == 1 ? cur_b_out : cur_c_out, sv);
                if (trig_out === 1'b1 && !m3) chk(DEC[4*hs_q+3], 0);
                if (m3 && !single_shunt_in) begin
                    chk(trig_out, tp);
                    chk(cur_valid_out, vp);
                end
                if (vp && m3 && !single_shunt_in) begin
                    chk(cur_a_out, e_cur[0]);
                    chk(cur_b_out, e_cur[1]);
                    chk(cur_c_out, e_cur[2]);
                end
                if (cur_valid_out === 1'b1) begin
                    ncv++;
                    chk(cur_a_out + cur_b_out + cur_c_out, 0);
                end
                if (pend && !single_shunt_in) begin
                    chk(no_sample_out, e_ns);
                    if (!e_ns) begin
                        chk(trigger_compare_value_out, e_cmp);
                        chk(trigger_output_polarity_out, e_pol);
                        chk(chan0_out !== sk && chan1_out !== sk && chan0_out !== chan1_out, 1);
                    end
                end
            end
            // trigger follows a compare match seen in this cycle
            tp = cnt_in === trigger_compare_value_out && cnt_down_in === trigger_output_polarity_out
                && no_sample_out === 1'b0;
            vp = adc_valid_in;
            if (adc_valid_in) begin
                e_cur[chan0_out] = adc0_in;
                e_cur[chan1_out] = adc1_in;
                e_cur[3 - chan0_out - chan1_out] = -(adc0_in + adc1_in);
            end
            if (cnt_in == 0) sub_e = 3'h1;
            else if (hs_gate_in !== hs_q && sub_e != 3'h7) sub_e = sub_e + 3'h1;
            sub_ok = single_shunt_in && (sub_ok || cnt_in == 0);
            // single shunt: code decoded at the trigger decision, applied to the next result
            if (trig_out === 1'b1 && !m3) begin
                have = 1'b1;
                pc = hs_q;
            end
            spv = single_shunt_in && have && adc_valid_in === 1'b1;
            if (spv) begin
                sph = DEC[4*pc+:2];
                sv = DEC[4*pc+2] ? -int'(adc0_in) : int'(adc0_in);
            end
            hs_q = hs_gate_in;
            m3 = !single_shunt_in;
            live = 1'b1;
            pend = update_in;
            // timing case of the larger-duty sampled phase
            if (update_in) begin
                sk = skip_of(sector_in);
                p = sk == 0 ? 1 : 0;
                q = sk == 2 ? 1 : 2;
                rf = dty(p) >= dty(q) ? p : q;
                dr = PER - dty(rf);
                dg = dty(rf) - dty(p + q - rf);
                {e_ns, e_pol} = 2'h0;
                if (dr >= DT + TN) e_cmp = CW'(PER);
                else if (dr > (DT + TN + TS) / 2) begin
                    e_cmp = CW'(PER + dr - DT - TN);
                    e_pol = 1'b1;
                end else if (dg > DT + TR + TS) e_cmp = CW'(dty(rf) - TS);
                else e_ns = 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(negedge core_clk_in);
        chk({trigger_compare_value_out, trigger_output_polarity_out, chan0_out, chan1_out, no_sample_out,
            trig_out, ls_gate_out, subperiod_out, cur_valid_out}, {16'h0, 9'h2, 3'h7, 3'h1, 1'b0});
        chk(cur_a_out | cur_b_out | cur_c_out, 0);
        $display("test reset done");
        resetn_in = 1'b1;
        @(negedge core_clk_in);
        // every sector with each timing case, both phase orders
        for (k = 1; k <= 6; k++) begin
            for (i = 0; i < 4; i++) begin
                sk = skip_of(k);
                put(sk, 99);
                a = sk == 0 ? 1 : 0;
                b = sk == 2 ? 1 : 2;
                c = k % 2 ? a : b;
                put(c, RD[i]);
                put(a + b - c, ND[i]);
                pulse(k, 4 * PER);
            end
        end
        $display("test sectors done");
        // random distinct duties below the top keep modulation bounded
        for (i = 0; i < 20; i++) begin
            if (i % 4 == 0) begin
                sector_in = 3'h5;
                update_in = 1'b1;
                @(negedge core_clk_in);
            end
            do begin
                a = 1 + {$random(seed)} % 99;
                b = 1 + {$random(seed)} % 99;
                c = 1 + {$random(seed)} % 99;
            end while (a == b || b == c || a == c);
            put(0, a);
            put(1, b);
            put(2, c);
            pulse(1 + {$random(seed)} % 6, 4 * PER);
        end
        $display("test random done");
        // single shunt rebuild; three duty orders reach all six non-zero codes, two in each
        single_shunt_in = 1'b1;
        ncv = 0;
        for (i = 0; i < 3; i++) begin
            put(i, 80);
            put((i + 1) % 3, 50);
            put((i + 2) % 3, 20);
            pulse(4, 4 * PER);
        end
        chk(ncv > 0, 1);
        $display("test single shunt done");
        results();
    end
endmodule : test_shunt_current_sampling_scheduler
`default_nettype wire
